// file: hw/asp_port.sv
`timescale 1ns/1ns
module asp_port #(
	parameter int WORD_W = asp_pkg::WORD_BITS,
	parameter int BYTE_W = asp_pkg::BYTE_BITS
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              sclk,
	input  wire logic              cs_n,
	input  wire logic              din,
	output logic                   dout,
	output logic                   dout_oe_n,
	output logic                   result_ready_n,
	input  wire logic              oscillator_in,
	output logic                   oscillator_out,
	output logic                   oscillator_oe_n,
	input  wire logic              osc_out_disable,
	input  wire logic [WORD_W-1:0] result_word,
	input  wire logic              result_load,
	output logic [BYTE_W-1:0]      cmd_byte,
	output logic                   cmd_valid,
	output logic                   result_dropped,
	output logic                   frame_active
);

	// Link-domain signals.
	logic                          frame_rst_n;
	logic [BYTE_W-1:0]             link_rx_byte;
	logic                          link_rx_tgl;
	logic                          link_rd_tgl;
	logic                          link_dout;
	logic [asp_pkg::CNT_BITS-1:0]  link_bit_cnt;

	// Synchronisers into the system clock.
	logic                          cs_s1;
	logic                          cs_s2;
	logic                          rx_s1;
	logic                          rx_s2;
	logic                          rx_s3;
	logic                          rd_s1;
	logic                          rd_s2;
	logic                          rd_s3;

	// Result slot.
	asp_pkg::asp_slot_t            slot;
	asp_pkg::asp_slot_t            next_slot;
	logic [WORD_W-1:0]             tx_word;
	logic [WORD_W-1:0]             pend_word;
	logic [WORD_W-1:0]             next_tx_word;
	logic [WORD_W-1:0]             next_pend_word;
	logic                          next_dropped;

	// Decoded events.
	wire                           rx_event;
	wire                           rd_event;
	wire                           slot_empty;
	wire                           slot_held;
	wire                           slot_pend;

	// The link logic runs from the shift clock; its counter, shift register and output bit are held in reset between frames.
	// With chip select tied low only the system reset clears the counter, so words are framed by count alone.
	assign frame_rst_n = reset_n & ~cs_n;

	asp_shift #(
		.WORD_W (WORD_W),
		.BYTE_W (BYTE_W)
	) u_shift (
		.sclk        (sclk),
		.frame_rst_n (frame_rst_n),
		.link_rst_n  (reset_n),
		.din         (din),
		.tx_word     (tx_word),
		.dout        (link_dout),
		.rx_byte     (link_rx_byte),
		.rx_tgl      (link_rx_tgl),
		.rd_tgl      (link_rd_tgl),
		.bit_cnt     (link_bit_cnt)
	);

	// The serial output bit leaves straight from the falling-edge flip-flop of the link domain.
	assign dout = link_dout;

	// The inverted master clock cannot be retimed without losing its edges, so it is a gate, not a flop.
	assign oscillator_out = ~oscillator_in;

	// Only the system reset clears the toggles, together with these flops, so each change is one event.
	assign rx_event   = rx_s2 ^ rx_s3;
	assign rd_event   = rd_s2 ^ rd_s3;
	assign slot_empty = (slot == asp_pkg::ASP_SLOT_EMPTY);
	assign slot_held  = (slot == asp_pkg::ASP_SLOT_HELD);
	assign slot_pend  = (slot == asp_pkg::ASP_SLOT_PEND);

	// Chip select is a pin, so it passes two flip-flops before steering the output enable.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
		end else begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
			rx_s3 <= 1'b0;
		end else begin
			rx_s1 <= link_rx_tgl;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_s1 <= 1'b0;
			rd_s2 <= 1'b0;
			rd_s3 <= 1'b0;
		end else begin
			rd_s1 <= link_rd_tgl;
			rd_s2 <= rd_s1;
			rd_s3 <= rd_s2;
		end
	end

	// Pin enables.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dout_oe_n <= asp_pkg::DOUT_OE_N_RESET;
		end else begin
			dout_oe_n <= cs_s2;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			oscillator_oe_n <= asp_pkg::OSC_OE_N_RESET;
		end else begin
			oscillator_oe_n <= osc_out_disable;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_active <= 1'b0;
		end else begin
			frame_active <= ~cs_s2;
		end
	end

	// Command bytes are taken from the link while the link holds them steady for the next eight bits.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= rx_event;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_byte <= asp_pkg::BYTE_RESET;
		end else if (rx_event) begin
			cmd_byte <= link_rx_byte;
		end
	end

	// The word offered to the host changes only when no unread word is held, or when the host has just
	// finished one; a word that arrives while one is held waits, and a newer one replaces it.
	always_comb begin
		next_slot      = slot;
		next_tx_word   = tx_word;
		next_pend_word = pend_word;
		next_dropped   = 1'b0;
		unique case (slot)
			asp_pkg::ASP_SLOT_EMPTY: begin
				if (result_load) begin
					next_tx_word = result_word;
					next_slot    = asp_pkg::ASP_SLOT_HELD;
				end
			end
			asp_pkg::ASP_SLOT_HELD: begin
				if (rd_event && result_load) begin
					next_tx_word = result_word;
				end else if (rd_event) begin
					next_slot = asp_pkg::ASP_SLOT_EMPTY;
				end else if (result_load) begin
					next_pend_word = result_word;
					next_slot      = asp_pkg::ASP_SLOT_PEND;
				end
			end
			asp_pkg::ASP_SLOT_PEND: begin
				if (rd_event && result_load) begin
					next_tx_word = result_word;
					next_slot    = asp_pkg::ASP_SLOT_HELD;
					next_dropped = 1'b1;
				end else if (rd_event) begin
					next_tx_word = pend_word;
					next_slot    = asp_pkg::ASP_SLOT_HELD;
				end else if (result_load) begin
					next_pend_word = result_word;
					next_dropped   = 1'b1;
				end
			end
			default: begin
				next_slot = asp_pkg::ASP_SLOT_EMPTY;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			slot <= asp_pkg::ASP_SLOT_EMPTY;
		end else begin
			slot <= next_slot;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_word <= asp_pkg::WORD_RESET;
		end else begin
			tx_word <= next_tx_word;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_word <= asp_pkg::WORD_RESET;
		end else begin
			pend_word <= next_pend_word;
		end
	end

	// Data-ready follows the slot; it drops in the cycle after the load and rises after a full read.
	// A read that ends while a newer word waits lets data-ready rise for no cycle at all, since the
	// newer word is ready at once.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_ready_n <= asp_pkg::READY_N_RESET;
		end else begin
			result_ready_n <= (next_slot == asp_pkg::ASP_SLOT_EMPTY);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_dropped <= 1'b0;
		end else begin
			result_dropped <= next_dropped;
		end
	end

endmodule

// file: inc/asp_pkg.sv
package asp_pkg;

	// Word and byte framing on the serial port.
	localparam int WORD_BITS   = 16;
	localparam int BYTE_BITS   = 8;
	localparam int CNT_BITS    = 4;

	// Clock rates, in hertz.
	localparam int CLK_HZ      = 10_000_000;
	localparam int SCLK_MAX_HZ = 5_000_000;

	// System and shift clock periods, in nanoseconds, and the least number of system clocks per shift-clock period.
	localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
	localparam int SCLK_PERIOD_NS = 1_000_000_000 / SCLK_MAX_HZ;
	localparam int SCLK_PERIOD_CYC = (SCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Synchroniser depth for every level and toggle that crosses into the system clock.
	localparam int SYNC_STAGES = 2;

	// Values after reset.
	localparam logic                 READY_N_RESET   = 1'b1;
	localparam logic                 DOUT_OE_N_RESET = 1'b1;
	localparam logic                 OSC_OE_N_RESET  = 1'b0;
	localparam logic                 DOUT_RESET      = 1'b0;
	localparam logic [WORD_BITS-1:0] WORD_RESET      = 16'h0000;
	localparam logic [BYTE_BITS-1:0] BYTE_RESET      = 8'h00;
	localparam logic [CNT_BITS-1:0]  CNT_RESET       = 4'h0;

	// Bit-counter values that close a byte and a word.
	localparam logic [2:0]          BYTE_LAST = 3'h7;
	localparam logic [CNT_BITS-1:0] WORD_LAST = 4'hf;

	// Result slot: empty, one word held for the host, or held with a newer word waiting.
	typedef enum logic [1:0] {
		ASP_SLOT_EMPTY = 2'b00,
		ASP_SLOT_HELD  = 2'b01,
		ASP_SLOT_PEND  = 2'b10
	} asp_slot_t;

endpackage

// file: hw/asp_shift.sv
`timescale 1ns/1ns
// Link-side shifter, clocked by the host shift clock only.
module asp_shift #(
	parameter int WORD_W = asp_pkg::WORD_BITS,
	parameter int BYTE_W = asp_pkg::BYTE_BITS
) (
	input  wire logic              sclk,
	input  wire logic              frame_rst_n,
	input  wire logic              link_rst_n,
	input  wire logic              din,
	input  wire logic [WORD_W-1:0] tx_word,
	output logic                   dout,
	output logic [BYTE_W-1:0]      rx_byte,
	output logic                   rx_tgl,
	output logic                   rd_tgl,
	output logic [asp_pkg::CNT_BITS-1:0] bit_cnt
);

	logic [BYTE_W-1:0] rx_shift;
	logic [WORD_W-1:0] tx_hold;
	logic [BYTE_W-1:0] next_rx_shift;
	logic              byte_done;
	logic              word_done;
	logic              word_start;

	// The counter holds the rising edges seen so far in the current word.
	assign next_rx_shift = {rx_shift[BYTE_W-2:0], din};
	assign byte_done     = (bit_cnt[2:0] == asp_pkg::BYTE_LAST);
	assign word_done     = (bit_cnt == asp_pkg::WORD_LAST);
	assign word_start    = (bit_cnt == asp_pkg::CNT_RESET);

	// Chip select high holds the counter, shift register and output bit in reset, so each frame starts at bit zero.
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt  <= asp_pkg::CNT_RESET;
			rx_shift <= asp_pkg::BYTE_RESET;
		end else begin
			bit_cnt  <= bit_cnt + 4'h1;
			rx_shift <= next_rx_shift;
		end
	end

	// Completed bytes and words are announced by toggles, which survive the frame reset.
	// Chip select may rise one half period after the last bit, long before the system clock has looked.
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_byte <= asp_pkg::BYTE_RESET;
		end else if (byte_done) begin
			rx_byte <= next_rx_shift;
		end
	end

	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_tgl <= 1'b0;
			rd_tgl <= 1'b0;
		end else begin
			rx_tgl <= rx_tgl ^ byte_done;
			rd_tgl <= rd_tgl ^ word_done;
		end
	end

	// The word is sampled once, at its first falling edge, so a later update cannot tear it.
	always_ff @(negedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_hold <= asp_pkg::WORD_RESET;
			dout    <= asp_pkg::DOUT_RESET;
		end else if (word_start) begin
			tx_hold <= tx_word;
			dout    <= tx_word[WORD_W-1];
		end else begin
			dout    <= tx_hold[~bit_cnt];
		end
	end

endmodule

// file: test/asp_port_sva.sv
`timescale 1ns/1ns
module asp_port_sva (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       cs_n,
	input wire logic       dout_oe_n,
	input wire logic       result_ready_n,
	input wire logic       result_load,
	input wire logic       result_dropped,
	input wire logic       oscillator_in,
	input wire logic       oscillator_out,
	input wire logic       oscillator_oe_n,
	input wire logic       osc_out_disable,
	input wire logic [7:0] cmd_byte,
	input wire logic       cmd_valid,
	input wire logic       frame_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// A word held, a second waiting, and a third that must push the waiting one out.
	sequence s_three_loads;
		result_load && result_ready_n ##1 result_load [*2];
	endsequence
	a_osc_off: assert property ($rose(osc_out_disable) |=> oscillator_oe_n) else $error("osc not released");
	a_osc_on: assert property ($fell(osc_out_disable) |=> !oscillator_oe_n) else $error("osc not driven");
	a_osc_inverted: assert property (!oscillator_oe_n |-> oscillator_out != oscillator_in) else $error("osc polarity");
	a_dout_drive: assert property (!cs_n [*5] |-> !dout_oe_n) else $error("dout not driven");
	a_dout_release: assert property (cs_n [*5] |-> dout_oe_n && !frame_active) else $error("dout not released");
	a_ready_on_load: assert property (result_load && result_ready_n |=> !result_ready_n) else $error("ready late");
	a_ready_holds: assert property ($fell(result_ready_n) |=> !result_ready_n [*3]) else $error("ready dropped");
	a_ready_release: assert property ($rose(result_ready_n) |-> $past(frame_active, 2)) else $error("ready rose");
	a_drop_pulse: assert property (s_three_loads |=> result_dropped ##1 !result_dropped) else $error("no drop");
	a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid && $stable(cmd_byte)) else $error("cmd pulse");
endmodule
bind asp_port asp_port_sva u_sva (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .dout_oe_n(dout_oe_n),
	.result_ready_n(result_ready_n), .result_load(result_load), .result_dropped(result_dropped),
	.oscillator_in(oscillator_in), .oscillator_out(oscillator_out), .oscillator_oe_n(oscillator_oe_n),
	.osc_out_disable(osc_out_disable), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .frame_active(frame_active));

// file: test/asp_host_model.sv
`timescale 1ns/1ns
module asp_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe_n
);
	logic three_wire;
	// Half a shift-clock period: just under the rate limit, and drifting against the system clock.
	localparam int HALF_NS = 105;
	// A released output shows the inverse of its last bit, so a read while released cannot match.
	wire line = dout_oe_n ? ~dout : dout;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		three_wire = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n = 1'b0;
		#400;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = tx[i];
			#(HALF_NS);
			sclk = 1'b1;
			rx[i] = line;
			#(HALF_NS);
		end
		cs_n = three_wire ? 1'b0 : 1'b1;
		din = ~din;
		#400;
	endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        clk, reset_n, oscillator_in, osc_out_disable, result_load;
	logic [15:0] result_word, w, c;
	wire         sclk, cs_n, din, dout, dout_oe_n, result_ready_n, oscillator_out, oscillator_oe_n;
	wire         cmd_valid, result_dropped, frame_active;
	wire  [7:0]  cmd_byte;
	int          n_fail, n_checks, n_drop;
	logic [7:0]  cmd_q[$];
	asp_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
	asp_port DUT (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe_n(dout_oe_n), .result_ready_n(result_ready_n), .oscillator_in(oscillator_in),
		.oscillator_out(oscillator_out), .oscillator_oe_n(oscillator_oe_n), .osc_out_disable(osc_out_disable),
		.result_word(result_word), .result_load(result_load), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
		.result_dropped(result_dropped), .frame_active(frame_active));
	always #50 clk = ~clk;
	always @(posedge clk) oscillator_in <= ~oscillator_in;
	always @(negedge clk) begin
		if (cmd_valid === 1'b1) cmd_q.push_back(cmd_byte);
		if (result_dropped === 1'b1) n_drop++;
	end
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wait_ready(input logic lvl);
		int i;
		for (i = 0; i < 60; i++) begin
			@(negedge clk);
			if (result_ready_n === lvl) break;
		end
		if (i == 60) begin
			n_fail++;
			$display("MISMATCH ready wait expected %b seen %b", lvl, result_ready_n);
			conclude();
		end
	endtask
	task load(input logic [15:0] v);
		@(posedge clk);
		result_word <= v;
		result_load <= 1'b1;
	endtask
	task idle;
		@(posedge clk);
		result_load <= 1'b0;
	endtask
	// Reads one word while sending a random command word, then checks both directions.
	task read_word(input logic [15:0] exp);
		logic [15:0] tx, rx;
		tx = 16'($urandom());
		cmd_q.delete();
		host.xfer(tx, rx);
		repeat (4) @(negedge clk);
		check("result word", rx, exp);
		check("cmd count", 16'(cmd_q.size()), 16'h0002);
		if (cmd_q.size() == 2) begin
			check("cmd high", {8'h00, cmd_q[0]}, {8'h00, tx[15:8]});
			check("cmd low", {8'h00, cmd_q[1]}, {8'h00, tx[7:0]});
		end
	endtask
	task one_word(input logic [15:0] v);
		load(v);
		idle();
		wait_ready(1'b0);
		read_word(v);
		wait_ready(1'b1);
	endtask
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		oscillator_in = 1'b0;
		osc_out_disable = 1'b0;
		result_load = 1'b0;
		result_word = 16'h0000;
		n_fail = 0;
		n_checks = 0;
		n_drop = 0;
		void'($urandom(61839));
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(negedge clk);
		check("ready idle", result_ready_n, 1'b1);
		for (int k = 0; k < 6; k++) begin
			w = (k == 0) ? 16'h8001 : 16'($urandom());
			load(w);
			idle();
			osc_out_disable <= k[0];
			wait_ready(1'b0);
			@(negedge clk);
			check("osc enable", oscillator_oe_n, k[0]);
			if (!k[0]) check("osc out", {15'h0000, oscillator_out}, {15'h0000, ~oscillator_in});
			read_word(w);
			wait_ready(1'b1);
		end
		w = 16'($urandom());
		c = 16'hffff;
		load(w);
		load(16'h0000);
		load(c);
		idle();
		repeat (3) @(negedge clk);
		check("drop count", 16'(n_drop), 16'h0001);
		read_word(w);
		check("ready kept", result_ready_n, 1'b0);
		read_word(c);
		wait_ready(1'b1);
		load(16'h1234);
		idle();
		wait_ready(1'b0);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(negedge clk);
		check("reset ready", result_ready_n, 1'b1);
		check("reset dout", dout_oe_n, 1'b1);
		@(posedge clk);
		reset_n <= 1'b1;
		host.three_wire = 1'b1;
		for (int k = 0; k < 2; k++) one_word(16'($urandom()));
		conclude();
	end
endmodule
